/* design/scp_pkg.sv */
`default_nettype none
package scp_pkg;
    // register indexes; byte address is four times the index
    localparam logic [9:0] SCP_IDX_CTRL = 10'h0A9;
    localparam logic [9:0] SCP_IDX_CFG = 10'h0AA;
    localparam logic [9:0] SCP_IDX_STAT = 10'h0AB;
    localparam logic [7:0] SCP_CTRL_RESET = 8'h00;
    localparam logic [7:0] SCP_CFG_RESET = 8'h00;
    // sequence generator
    localparam int SCP_LFSR_W = 12;
    localparam logic [11:0] SCP_LFSR_SEED = 12'h001;
    localparam int SCP_MSB_SHORT = 7;
    localparam int SCP_MSB_LONG = 11;
    localparam int SCP_CNT_W = 8;
    // normal sense clock pin select codes
    localparam logic [1:0] SCP_OUT_NONE = 2'h0;
    localparam logic [1:0] SCP_OUT_CMP0 = 2'h1;
    localparam logic [1:0] SCP_OUT_CMP1 = 2'h2;
    localparam logic [1:0] SCP_OUT_SCLK = 2'h3;
    localparam logic [1:0] SCP_HTRANS_NONSEQ = 2'h2;

    // sequence_prescaler_control, bit 7 down to bit 0
    typedef struct packed {
        logic sense_clock_route;
        logic sense_clock_invert;
        logic sequence_length_select;
        logic sequence_gen_enable;
        logic divider_bypass;
        logic [2:0] divider_ratio_select;
    } scp_ctrl_t;

    // sense configuration, bit 7 down to bit 0
    typedef struct packed {
        logic sigma_delta_sensing_mode;
        logic sigma_delta_clock_source_pick;
        logic [1:0] sense_clock_rate_select;
        logic [1:0] sense_pin_output_select;
        logic port1_pin_route_select;
        logic port0_pin_route_select;
    } scp_cfg_t;

    // block state seen by software
    typedef struct packed {
        logic [11:0] lfsr;
        logic seq_bit;
        logic presc_level;
        logic sense_clk;
        logic normal_clk;
    } scp_stat_t;
endpackage
`default_nettype wire

/* design/scp_sense_clock.sv */
`default_nettype none
module scp_sense_clock
    import scp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] cmp_out,
    output logic pin_p1_out,
    output logic pin_p0_out,
    output logic presc_tick,
    output logic seq_bit
);
    function automatic logic [7:0] div_mask(input logic [2:0] ratio);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i <= int'(ratio)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [11:0] lfsr_step(input logic [11:0] v, input logic long);
        logic fb;
        fb = long ? (v[11] ^ v[5] ^ v[3] ^ v[0]) : (v[7] ^ v[5] ^ v[4] ^ v[3]);
        return long ? {v[10:0], fb} : {4'h0, v[6:0], fb};
    endfunction

    function automatic logic [31:0] reg_read(input logic [9:0] idx, input scp_ctrl_t c,
                                             input scp_cfg_t g, input scp_stat_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (idx == SCP_IDX_CTRL) begin
            r[7:0] = c;
        end else if (idx == SCP_IDX_CFG) begin
            r[7:0] = g;
        end else if (idx == SCP_IDX_STAT) begin
            r[15:0] = s;
        end
        return r;
    endfunction

    // bus and register state
    scp_ctrl_t ctl_q, ctl_d;
    scp_cfg_t cfg_q, cfg_d;
    logic wr_q, wr_d;
    logic [9:0] idx_q, idx_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic take;
    scp_stat_t stat;

    // clocking state
    logic [SCP_CNT_W-1:0] cnt_q, cnt_d;
    logic [11:0] lfsr_q, lfsr_d;
    logic pin_p1_q, pin_p1_d, pin_p0_q, pin_p0_d;
    logic presc_level, normal_clk, sense_clk, routed_clk, normal_pin;

    assign take = hsel && htrans == SCP_HTRANS_NONSEQ && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_comb begin
        ctl_d = ctl_q;
        cfg_d = cfg_q;
        wr_d = wr_q;
        idx_d = idx_q;
        hrdata_d = hrdata_q;
        if (wr_q && idx_q == SCP_IDX_CTRL) begin
            ctl_d = hwdata[7:0];
        end
        if (wr_q && idx_q == SCP_IDX_CFG) begin
            cfg_d = hwdata[7:0];
        end
        if (hready) begin
            wr_d = take && hwrite;
            idx_d = haddr[11:2];
        end
        // read the next values so a read right after a write sees it
        if (take && !hwrite) begin
            hrdata_d = reg_read(haddr[11:2], ctl_d, cfg_d, stat);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= SCP_CTRL_RESET;
            cfg_q <= SCP_CFG_RESET;
            wr_q <= 1'b0;
            idx_q <= 10'h000;
            hrdata_q <= 32'h0000_0000;
        end else begin
            ctl_q <= ctl_d;
            cfg_q <= cfg_d;
            wr_q <= wr_d;
            idx_q <= idx_d;
            hrdata_q <= hrdata_d;
        end
    end

    // prescaler: tick once per divisor, or every cycle in bypass
    always_comb begin
        presc_tick = ctl_q.divider_bypass ||
            ((cnt_q & div_mask(ctl_q.divider_ratio_select)) ==
             div_mask(ctl_q.divider_ratio_select));
        // a flop cannot make hclk itself, so bypass shows hclk/2 on the pin
        presc_level = ctl_q.divider_bypass ? cnt_q[0] :
            cnt_q[ctl_q.divider_ratio_select];
        normal_clk = cnt_q[cfg_q.sense_clock_rate_select];
        seq_bit = ctl_q.sequence_gen_enable &&
            (ctl_q.sequence_length_select ? lfsr_q[SCP_MSB_LONG] :
             lfsr_q[SCP_MSB_SHORT]);
        if (cfg_q.sigma_delta_sensing_mode) begin
            sense_clk = cfg_q.sigma_delta_clock_source_pick ? seq_bit : presc_level;
        end else begin
            sense_clk = normal_clk;
        end
        routed_clk = sense_clk ^ ctl_q.sense_clock_invert;
        unique case (cfg_q.sense_pin_output_select)
            SCP_OUT_NONE: normal_pin = 1'b0;
            SCP_OUT_CMP0: normal_pin = cmp_out[0];
            SCP_OUT_CMP1: normal_pin = cmp_out[1];
            SCP_OUT_SCLK: normal_pin = sense_clk;
        endcase
        pin_p1_d = (ctl_q.sense_clock_route && cfg_q.port1_pin_route_select) ?
            routed_clk : normal_pin;
        pin_p0_d = (ctl_q.sense_clock_route && cfg_q.port0_pin_route_select) ?
            routed_clk : normal_pin;
        cnt_d = cnt_q + 8'h01;
        lfsr_d = lfsr_q;
        if (!ctl_q.sequence_gen_enable) begin
            lfsr_d = SCP_LFSR_SEED;
        end else if (presc_tick) begin
            lfsr_d = lfsr_step(lfsr_q, ctl_q.sequence_length_select);
            // a length switch can leave the short window all zero
            if (lfsr_d == 12'h000) begin
                lfsr_d = SCP_LFSR_SEED;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 8'h00;
            lfsr_q <= SCP_LFSR_SEED;
            pin_p1_q <= 1'b0;
            pin_p0_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lfsr_q <= lfsr_d;
            pin_p1_q <= pin_p1_d;
            pin_p0_q <= pin_p0_d;
        end
    end

    assign pin_p1_out = pin_p1_q;
    assign pin_p0_out = pin_p0_q;
    assign stat = '{lfsr: lfsr_q, seq_bit: seq_bit, presc_level: presc_level,
                    sense_clk: sense_clk, normal_clk: normal_clk};

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // tick only where the count just closes a whole divisor period
    AST_DIV_MASK: assert property (
        (presc_tick && !ctl_q.divider_bypass) |->
            ((9'(cnt_q) + 9'h001) & ((9'h002 << ctl_q.divider_ratio_select) - 9'h001))
            == 9'h000)
        else $error("prescaler tick off its divisor");
    AST_DIV_TWO: assert property (
        (presc_tick && !ctl_q.divider_bypass && ctl_q.divider_ratio_select == 3'h0
         && $stable(ctl_q)) |=> (!presc_tick || $changed(ctl_q)))
        else $error("divide by two ticks back to back");
    AST_BYPASS: assert property (
        ctl_q.divider_bypass |-> presc_tick)
        else $error("bypass did not pass every clock");
    AST_SEQ_HOLD: assert property (
        (ctl_q.sequence_gen_enable && !presc_tick) |=> lfsr_q == $past(lfsr_q))
        else $error("sequence moved without prescaler output");
    AST_SEQ_OFF: assert property (
        !ctl_q.sequence_gen_enable |-> !seq_bit)
        else $error("disabled generator output not zero");
    AST_SEQ_LEN: assert property (
        ctl_q.sequence_gen_enable |-> seq_bit == (ctl_q.sequence_length_select ?
            lfsr_q[SCP_MSB_LONG] : lfsr_q[SCP_MSB_SHORT]))
        else $error("sequence output not the selected msb");
    AST_ROUTE_P1: assert property (
        (ctl_q.sense_clock_route && cfg_q.port1_pin_route_select) |=>
            pin_p1_out == ($past(sense_clk) ^ $past(ctl_q.sense_clock_invert)))
        else $error("port1 pin not carrying routed sense clock");
    AST_ROUTE_P0: assert property (
        (!ctl_q.sense_clock_route) |=> pin_p0_out == $past(normal_pin))
        else $error("port0 pin ignores normal selection");
    AST_SD_SRC: assert property (
        (cfg_q.sigma_delta_sensing_mode && cfg_q.sigma_delta_clock_source_pick) |->
            sense_clk == seq_bit)
        else $error("sigma-delta clock not from sequence");
    AST_NORMAL_RATE: assert property (
        !cfg_q.sigma_delta_sensing_mode |-> sense_clk == cnt_q[cfg_q.sense_clock_rate_select])
        else $error("normal sense clock rate wrong");
    AST_SEQ_NONZERO: assert property (
        (ctl_q.sequence_gen_enable && presc_tick) |=> lfsr_q != 12'h000)
        else $error("sequence register went to zero");

    COV_BYPASS: cover property (ctl_q.divider_bypass && ctl_q.sequence_gen_enable ##1 seq_bit);
    COV_DIV256: cover property (ctl_q.divider_ratio_select == 3'h7 && presc_tick);
    COV_ROUTE: cover property (ctl_q.sense_clock_route && $rose(pin_p1_out));
    COV_LONG: cover property (ctl_q.sequence_length_select && $rose(seq_bit));
endmodule
`default_nettype wire

/* sim/test_sense_clock_prescaler_prs.sv */
`default_nettype none
`define chk(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
module test_sense_clock_prescaler_prs
    import scp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0] htrans = 2'h0, cmp_out = 2'h0;
    logic [2:0] hsize = 3'h2, rt;
    logic hreadyout, hresp, pin_p1_out, pin_p0_out, presc_tick, seq_bit, inv, len, pv, pc;
    logic [11:0] m;
    int seed = 32'h1a98, miscompares = 0, check_count = 0, c;

    always #2 hclk = ~hclk;
    always @(posedge hclk) cmp_out <= 2'($random(seed));

    scp_sense_clock i_scp_sense_clock (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cmp_out(cmp_out), .pin_p1_out(pin_p1_out), .pin_p0_out(pin_p0_out),
        .presc_tick(presc_tick), .seq_bit(seq_bit));

    function automatic logic [11:0] step(input logic [11:0] v, input logic l);
        if (l) return {v[10:0], v[11] ^ v[5] ^ v[3] ^ v[0]};
        return {4'h0, v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // waits on hready without assuming a latency; the watchdog ends a hang
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, idx, 2'h0};
        htrans <= SCP_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `chk(d, {24'h0, e})
        `chk(hresp, 1'b0)
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // whole run is about 8k cycles
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(SCP_IDX_CTRL, SCP_CTRL_RESET);
        rd(SCP_IDX_CFG, SCP_CFG_RESET);
        bus(1'b1, SCP_IDX_CTRL, 8'h5A);
        rd(SCP_IDX_CTRL, 8'h5A);
        bus(1'b1, 10'h010, 8'hFF);
        rd(10'h010, 8'h00);
        $display("registers done");
        // 512 cycles hold a whole number of periods, so phase does not matter
        for (int r = 0; r < 9; r++) begin
            bus(1'b1, SCP_IDX_CTRL, (r == 8) ? 8'h08 | 8'($random(seed) & 7) : 8'(r));
            c = 0;
            repeat (512) begin
                @(negedge hclk);
                if (presc_tick === 1'b1) c++;
            end
            `chk(c, (r == 8) ? 512 : 512 >> (r + 1))
        end
        $display("prescaler done");
        bus(1'b1, SCP_IDX_CFG, 8'hC1);
        for (int k = 0; k < 4; k++) begin
            len = k[0];
            inv = 1'($random(seed));
            rt = (k < 2) ? 3'h0 : 3'($random(seed) & 3);
            bus(1'b1, SCP_IDX_CTRL, {1'b1, inv, len, 1'b0, k == 0, rt});
            repeat (2) @(negedge hclk);
            repeat (8) begin
                @(negedge hclk);
                `chk(seq_bit, 1'b0)
                `chk(pin_p0_out, inv)
            end
            bus(1'b1, SCP_IDX_CTRL, {1'b1, inv, len, 1'b1, k == 0, rt});
            m = SCP_LFSR_SEED;
            pv = 1'b0;
            // pin lags the sequence by one registered stage
            repeat (300) begin
                @(negedge hclk);
                `chk(seq_bit, len ? m[SCP_MSB_LONG] : m[SCP_MSB_SHORT])
                `chk(pin_p0_out, pv ^ inv)
                `chk(pin_p1_out, 1'b0)
                pv = seq_bit;
                if (presc_tick === 1'b1) m = step(m, len);
            end
            $display("sequence pass %0d done", k);
        end
        bus(1'b1, SCP_IDX_CTRL, 8'h80);
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, SCP_IDX_CFG, {2'h0, 2'(r), SCP_OUT_CMP1, 2'h1});
            repeat (2) @(negedge hclk);
            pv = pin_p0_out;
            pc = cmp_out[1];
            c = 0;
            repeat (256) begin
                @(negedge hclk);
                if (pin_p0_out !== pv) c++;
                `chk(pin_p1_out, pc)
                pv = pin_p0_out;
                pc = cmp_out[1];
            end
            `chk(c, 256 >> r)
        end
        $display("normal rate done");
        // prescaler as sigma-delta source, port1 routed inverted, port0 normal select
        for (int j = 0; j < 2; j++) begin
            rt = 3'($random(seed));
            bus(1'b1, SCP_IDX_CTRL, {5'h18, rt});
            bus(1'b1, SCP_IDX_CFG, {4'h8, (j == 1) ? SCP_OUT_CMP0 : SCP_OUT_SCLK, 2'h2});
            repeat (2) @(negedge hclk);
            pv = pin_p1_out;
            pc = cmp_out[0];
            c = 0;
            repeat (256) begin
                @(negedge hclk);
                if (pin_p1_out !== pv) c++;
                `chk(pin_p0_out, (j == 1) ? pc : ~pin_p1_out)
                pv = pin_p1_out;
                pc = cmp_out[0];
            end
            `chk(c, 256 >> rt)
        end
        $display("prescaler source done");
        // reset in mid-run must bring back the idle generator and cleared registers
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(negedge hclk);
        `chk(seq_bit, 1'b0)
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(SCP_IDX_CTRL, SCP_CTRL_RESET);
        rd(SCP_IDX_CFG, SCP_CFG_RESET);
        bus(1'b0, SCP_IDX_STAT, 8'h00);
        `chk(d[31:3], 29'h0000_0002)
        $display("mid-run reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
